// file: current_source_model.sv
// Measurement converter model delivering current samples
`timescale 1ns/1ps
module current_source_model (
	input  wire logic               mclk_in,
	input  wire logic               arst_n_in,
	input  wire logic               req_in,
	input  wire logic signed [16:0] level_ua_in,
	output logic signed      [16:0] sample_out,
	output logic                    sample_valid_out
);
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sample_out <= 17'sh00000;
			sample_valid_out <= 1'b0;
		end else if (req_in) begin
			sample_out <= level_ua_in;
			sample_valid_out <= 1'b1;
		end else begin
			// Word is meaningless beside a low strobe
			sample_out <= ~sample_out;
			sample_valid_out <= 1'b0;
		end
	end
endmodule : current_source_model

// file: display_scaler_params.svh
// Register offsets, field positions, reset values and timing counts of the display scaler
`ifndef DISPLAY_SCALER_PARAMS_SVH
`define DISPLAY_SCALER_PARAMS_SVH

`define REG_CTRL          7'h00
`define REG_ZERO_SCALE    7'h01
`define REG_FULL_SCALE    7'h02
`define REG_LOWER_MARGIN  7'h03
`define REG_UPPER_MARGIN  7'h04
`define REG_MIN_EXCURSION 7'h05
`define REG_HOLD_TIME     7'h06
`define REG_POINT_COUNT   7'h07
`define REG_DISPLAY_VALUE 7'h08
`define REG_DISPLAY_STAT  7'h09
`define REG_X_REGION      2'h1
`define REG_Y_REGION      2'h2

`define CTRL_CHAR_LSB     0
`define CTRL_RANGE_BIT    2
`define CTRL_DROP_BIT     3
`define CTRL_SHOW_BIT     4

`define RST_ZERO_SCALE    14'h0000
`define RST_FULL_SCALE    14'h03E8

`define BASE_4MA_UA       18'sh00FA0
`define NOM_MAX_UA        18'sh04E20
`define LO_STEP_UA        18'sh00004
`define HI_STEP_UA        18'sh00014
`define RECIP_16MA        16'h4189
`define RECIP_20MA        16'h346E
`define PERMILLE_FULL     12'sh3E8
`define DISP_MIN          (-24'sh0003E7)
`define DISP_MAX          24'sh00270F
`define MAX_POINTS        5'h14
`define MIN_POINTS        5'h02
`define HOLD_MAX          8'hC7

`define HOLD_STEP_NS      32'h05F5E100
`define CLK_PERIOD_NS     32'h00000019
`define HOLD_STEP_CYCLES  (`HOLD_STEP_NS / `CLK_PERIOD_NS)

`endif

// file: display_scaler_pkg.sv
// Types shared by the display scaler
package display_scaler_pkg;
	typedef enum logic [1:0] {CHAR_LINEAR, CHAR_SQUARE, CHAR_SQRT, CHAR_USER} char_mode_t;
	typedef enum logic [2:0] {CODE_VALUE, CODE_OVERFLOW, CODE_BELOW, CODE_ABOVE, CODE_TOO_FEW} code_t;
	typedef enum {ST_IDLE, ST_NORM, ST_SHAPE, ST_SQRT, ST_SEG, ST_DIV, ST_SCALE, ST_DONE} state_t;
endpackage : display_scaler_pkg

// file: display_value_scaler.sv
// Display value scaler: normalization, characteristics, peak hold and register port
`timescale 1ns/1ps
`include "display_scaler_params.svh"
module display_value_scaler #(
	parameter int HOLD_TICK_CYCLES = `HOLD_STEP_CYCLES
) (
	input  wire logic                       mclk_in,
	input  wire logic                       arst_n_in,
	input  wire logic signed [16:0]         sample_in,
	input  wire logic                       sample_valid_in,
	input  wire logic                       esc_button_in,
	input  wire logic        [6:0]          addr_in,
	input  wire logic        [15:0]         wr_data_in,
	input  wire logic                       wr_strobe_in,
	input  wire logic                       rd_strobe_in,
	output logic             [15:0]         rd_data_out,
	output logic signed      [13:0]         display_value_out,
	output display_scaler_pkg::code_t       display_code_out,
	output logic                            display_valid_out,
	output logic                            held_active_out
);
	import display_scaler_pkg::*;

	char_mode_t         char_reg;
	logic               range_0_20_reg;
	logic               drop_detect_reg;
	logic               show_held_reg;
	logic signed [13:0] zero_scale_reg;
	logic signed [13:0] full_scale_reg;
	logic        [9:0]  lower_margin_reg;
	logic        [7:0]  upper_margin_reg;
	logic        [13:0] min_exc_reg;
	logic        [7:0]  hold_time_reg;
	logic        [4:0]  point_count_reg;
	logic signed [11:0] x_mem [0:19];
	logic signed [13:0] y_mem [0:19];

	state_t             state_reg;
	logic signed [16:0] sample_reg;
	logic signed [23:0] norm_reg;
	logic signed [23:0] unit_reg;
	logic signed [23:0] w_reg;
	logic               below_reg;
	logic               above_reg;
	logic               too_few_reg;
	logic        [39:0] rad_reg;
	logic        [19:0] root_reg;
	logic        [4:0]  bit_reg;
	logic signed [15:0] npm_reg;
	logic        [4:0]  seg_reg;
	logic signed [13:0] yl_reg;
	logic               neg_reg;
	logic               div_start_reg;
	logic        [31:0] div_num_reg;
	logic        [31:0] div_den_reg;
	logic        [31:0] quotient;
	logic               div_done;

	logic signed [23:0] ext_reg;
	logic               ext_valid_reg;
	logic               armed_reg;
	logic signed [13:0] held_value_reg;
	logic        [7:0]  hold_left_reg;
	logic        [31:0] tick_reg;
	logic               esc_meta_reg;
	logic               esc_sync_reg;
	logic               esc_prev_reg;

	logic signed [17:0] diff;
	logic signed [35:0] norm_prod;
	logic signed [17:0] lo_lim;
	logic signed [17:0] hi_lim;
	logic signed [47:0] norm_sq;
	logic signed [35:0] npm_prod;
	logic        [19:0] trial_root;
	logic        [39:0] trial_sq;
	logic signed [39:0] scale_prod;
	logic signed [14:0] span;
	logic signed [16:0] seg_dx;
	logic signed [31:0] seg_num;
	code_t              live_code;
	logic               peak_event;
	logic signed [23:0] peak_value;
	logic signed [23:0] excursion;
	logic               is_done_value;
	logic        [4:0]  seg_next;

	function automatic logic [31:0] magnitude(input logic signed [31:0] v);
		magnitude = v[31] ? 32'(-v) : 32'(v);
	endfunction : magnitude

	// Register writes
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			char_reg         <= CHAR_LINEAR;
			range_0_20_reg   <= 1'b0;
			drop_detect_reg  <= 1'b0;
			show_held_reg    <= 1'b0;
			zero_scale_reg   <= `RST_ZERO_SCALE;
			full_scale_reg   <= `RST_FULL_SCALE;
			lower_margin_reg <= 10'h000;
			upper_margin_reg <= 8'h00;
			min_exc_reg      <= 14'h0000;
			hold_time_reg    <= 8'h00;
			point_count_reg  <= 5'h00;
		end else if (wr_strobe_in) begin
			case (addr_in)
				`REG_CTRL: begin
					char_reg        <= char_mode_t'(wr_data_in[`CTRL_CHAR_LSB +: 2]);
					range_0_20_reg  <= wr_data_in[`CTRL_RANGE_BIT];
					drop_detect_reg <= wr_data_in[`CTRL_DROP_BIT];
					show_held_reg   <= wr_data_in[`CTRL_SHOW_BIT];
				end
				`REG_ZERO_SCALE:    zero_scale_reg   <= wr_data_in[13:0];
				`REG_FULL_SCALE:    full_scale_reg   <= wr_data_in[13:0];
				`REG_LOWER_MARGIN:  lower_margin_reg <= wr_data_in[9:0];
				`REG_UPPER_MARGIN:  upper_margin_reg <= wr_data_in[7:0];
				`REG_MIN_EXCURSION: min_exc_reg      <= wr_data_in[13:0];
				`REG_HOLD_TIME:     hold_time_reg    <= (wr_data_in[7:0] > `HOLD_MAX) ? `HOLD_MAX : wr_data_in[7:0];
				`REG_POINT_COUNT:   point_count_reg  <= (wr_data_in[4:0] > `MAX_POINTS) ? `MAX_POINTS : wr_data_in[4:0];
				default: begin
				end
			endcase
		end
	end

	// Point table, points kept in ascending X order by software
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			for (int i = 0; i < 20; i++) begin
				x_mem[i] <= 12'sh000;
				y_mem[i] <= 14'sh0000;
			end
		end else if (wr_strobe_in && addr_in[4:0] < `MAX_POINTS) begin
			if (addr_in[6:5] == `REG_X_REGION)
				x_mem[addr_in[4:0]] <= wr_data_in[11:0];
			if (addr_in[6:5] == `REG_Y_REGION)
				y_mem[addr_in[4:0]] <= wr_data_in[13:0];
		end
	end

	// Register reads, data in the following cycle only
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_data_out <= 16'h0000;
		end else if (rd_strobe_in) begin
			rd_data_out <= 16'h0000;
			if (addr_in[6:5] == `REG_X_REGION && addr_in[4:0] < `MAX_POINTS)
				rd_data_out <= 16'(x_mem[addr_in[4:0]]);
			else if (addr_in[6:5] == `REG_Y_REGION && addr_in[4:0] < `MAX_POINTS)
				rd_data_out <= 16'(y_mem[addr_in[4:0]]);
			else begin
				case (addr_in)
					`REG_CTRL:          rd_data_out <= {11'h000, show_held_reg, drop_detect_reg, range_0_20_reg, char_reg};
					`REG_ZERO_SCALE:    rd_data_out <= 16'(zero_scale_reg);
					`REG_FULL_SCALE:    rd_data_out <= 16'(full_scale_reg);
					`REG_LOWER_MARGIN:  rd_data_out <= {6'h00, lower_margin_reg};
					`REG_UPPER_MARGIN:  rd_data_out <= {8'h00, upper_margin_reg};
					`REG_MIN_EXCURSION: rd_data_out <= {2'h0, min_exc_reg};
					`REG_HOLD_TIME:     rd_data_out <= {8'h00, hold_time_reg};
					`REG_POINT_COUNT:   rd_data_out <= {11'h000, point_count_reg};
					`REG_DISPLAY_VALUE: rd_data_out <= 16'(display_value_out);
					`REG_DISPLAY_STAT:  rd_data_out <= {12'h000, held_active_out, display_code_out};
					default:            rd_data_out <= 16'h0000;
				endcase
			end
		end else begin
			rd_data_out <= 16'h0000;
		end
	end

	// Normalization and permissible range
	assign diff      = 18'(sample_reg) - (range_0_20_reg ? 18'sh00000 : `BASE_4MA_UA);
	assign norm_prod = diff * $signed({2'b00, (range_0_20_reg ? `RECIP_20MA : `RECIP_16MA)});
	assign lo_lim    = range_0_20_reg ? 18'sh00000 : (`BASE_4MA_UA - $signed({8'h00, lower_margin_reg}) * `LO_STEP_UA);
	assign hi_lim    = `NOM_MAX_UA + $signed({10'h000, upper_margin_reg}) * `HI_STEP_UA;
	assign norm_sq   = norm_reg * norm_reg;
	assign npm_prod  = norm_reg * `PERMILLE_FULL;
	assign trial_root = root_reg | (20'h00001 << bit_reg);
	assign trial_sq  = trial_root * trial_root;
	assign span      = 15'(full_scale_reg) - 15'(zero_scale_reg);
	assign scale_prod = unit_reg * span;
	assign seg_next  = seg_reg + 5'h01;
	assign seg_dx    = 17'(x_mem[seg_next]) - 17'(x_mem[seg_reg]);
	assign seg_num   = 32'(npm_reg - 16'(x_mem[seg_reg])) * 32'(15'(y_mem[seg_next]) - 15'(y_mem[seg_reg]));

	// Processing sequence, one pass per sample
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg     <= ST_IDLE;
			sample_reg    <= 17'sh00000;
			norm_reg      <= 24'sh000000;
			unit_reg      <= 24'sh000000;
			w_reg         <= 24'sh000000;
			below_reg     <= 1'b0;
			above_reg     <= 1'b0;
			too_few_reg   <= 1'b0;
			rad_reg       <= 40'h0000000000;
			root_reg      <= 20'h00000;
			bit_reg       <= 5'h00;
			npm_reg       <= 16'sh0000;
			seg_reg       <= 5'h00;
			yl_reg        <= 14'sh0000;
			neg_reg       <= 1'b0;
			div_start_reg <= 1'b0;
			div_num_reg   <= 32'h00000000;
			div_den_reg   <= 32'h00000000;
		end else begin
			div_start_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					too_few_reg <= 1'b0;
					if (sample_valid_in) begin
						sample_reg <= sample_in;
						state_reg  <= ST_NORM;
					end
				end
				ST_NORM: begin
					norm_reg  <= norm_prod[35:12];
					below_reg <= 18'(sample_reg) < lo_lim;
					above_reg <= 18'(sample_reg) > hi_lim;
					state_reg <= ST_SHAPE;
				end
				ST_SHAPE: begin
					case (char_reg)
						CHAR_LINEAR: begin
							unit_reg  <= norm_reg;
							state_reg <= ST_SCALE;
						end
						CHAR_SQUARE: begin
							unit_reg  <= norm_sq[39:16];
							state_reg <= ST_SCALE;
						end
						CHAR_SQRT: begin
							if (norm_reg < 0) begin
								unit_reg  <= 24'sh000000;
								state_reg <= ST_SCALE;
							end else begin
								rad_reg   <= {norm_reg[23:0], 16'h0000};
								root_reg  <= 20'h00000;
								bit_reg   <= 5'h13;
								state_reg <= ST_SQRT;
							end
						end
						default: begin
							if (point_count_reg < `MIN_POINTS) begin
								too_few_reg <= 1'b1;
								state_reg   <= ST_DONE;
							end else begin
								npm_reg   <= npm_prod[31:16];
								seg_reg   <= 5'h00;
								state_reg <= ST_SEG;
							end
						end
					endcase
				end
				ST_SQRT: begin
					if (trial_sq <= rad_reg)
						root_reg <= trial_root;
					if (bit_reg == 5'h00) begin
						unit_reg  <= (trial_sq <= rad_reg) ? 24'(trial_root) : 24'(root_reg);
						state_reg <= ST_SCALE;
					end else begin
						bit_reg <= bit_reg - 5'h01;
					end
				end
				ST_SEG: begin
					// Lowest segment whose upper X lies above; last one past the end
					if (seg_next == point_count_reg - 5'h01 || npm_reg < 16'(x_mem[seg_next])) begin
						yl_reg        <= y_mem[seg_reg];
						neg_reg       <= seg_num[31];
						div_num_reg   <= magnitude(seg_num);
						div_den_reg   <= 32'(seg_dx);
						div_start_reg <= 1'b1;
						state_reg     <= ST_DIV;
					end else begin
						seg_reg <= seg_next;
					end
				end
				ST_DIV: begin
					if (div_done) begin
						w_reg     <= (neg_reg ? -24'(quotient) : 24'(quotient)) + 24'(yl_reg);
						state_reg <= ST_DONE;
					end
				end
				ST_SCALE: begin
					w_reg     <= scale_prod[39:16] + 24'(zero_scale_reg);
					state_reg <= ST_DONE;
				end
				ST_DONE: begin
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	seg_divider #(
		.W(32)
	) u_seg_divider (
		.mclk_in      (mclk_in),
		.arst_n_in    (arst_n_in),
		.start_in     (div_start_reg),
		.dividend_in  (div_num_reg),
		.divisor_in   (div_den_reg),
		.quotient_out (quotient),
		.done_out     (div_done)
	);

	// Warning selection for the finished sample
	always_comb begin
		if (too_few_reg)
			live_code = CODE_TOO_FEW;
		else if (below_reg)
			live_code = CODE_BELOW;
		else if (above_reg)
			live_code = CODE_ABOVE;
		else if (w_reg < `DISP_MIN || w_reg > `DISP_MAX)
			live_code = CODE_OVERFLOW;
		else
			live_code = CODE_VALUE;
	end

	// Peak or drop detection on valid results
	assign is_done_value = (state_reg == ST_DONE) && (live_code == CODE_VALUE);
	assign excursion     = drop_detect_reg ? (w_reg - ext_reg) : (ext_reg - w_reg);
	assign peak_event    = is_done_value && ext_valid_reg && armed_reg && (excursion > 24'sh000000)
	                       && (excursion >= $signed({10'h000, min_exc_reg}));
	assign peak_value    = ext_reg;

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ext_reg       <= 24'sh000000;
			ext_valid_reg <= 1'b0;
			armed_reg     <= 1'b0;
		end else if (is_done_value) begin
			ext_valid_reg <= 1'b1;
			if (!ext_valid_reg || peak_event) begin
				ext_reg   <= w_reg;
				armed_reg <= 1'b0;
			end else if (drop_detect_reg ? (w_reg < ext_reg) : (w_reg > ext_reg)) begin
				ext_reg   <= w_reg;
				armed_reg <= 1'b1;
			end else if (!armed_reg) begin
				// Follow the retreat until a new swing starts
				ext_reg <= w_reg;
			end
		end
	end

	// Escape button synchroniser and edge
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			esc_meta_reg <= 1'b0;
			esc_sync_reg <= 1'b0;
			esc_prev_reg <= 1'b0;
		end else begin
			esc_meta_reg <= esc_button_in;
			esc_sync_reg <= esc_meta_reg;
			esc_prev_reg <= esc_sync_reg;
		end
	end

	// Hold timer in 0.1 s steps
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			held_active_out <= 1'b0;
			held_value_reg  <= 14'sh0000;
			hold_left_reg   <= 8'h00;
			tick_reg        <= 32'h00000000;
		end else if (peak_event) begin
			held_active_out <= show_held_reg || (hold_time_reg != 8'h00);
			held_value_reg  <= peak_value[13:0];
			hold_left_reg   <= hold_time_reg;
			tick_reg        <= 32'h00000000;
		end else if (esc_sync_reg && !esc_prev_reg) begin
			held_active_out <= 1'b0;
		end else if (held_active_out && hold_left_reg != 8'h00) begin
			if (tick_reg == 32'(HOLD_TICK_CYCLES - 1)) begin
				tick_reg      <= 32'h00000000;
				hold_left_reg <= hold_left_reg - 8'h01;
				if (hold_left_reg == 8'h01)
					held_active_out <= 1'b0;
			end else begin
				tick_reg <= tick_reg + 32'h00000001;
			end
		end
	end

	// Display output
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			display_value_out <= 14'sh0000;
			display_code_out  <= CODE_VALUE;
			display_valid_out <= 1'b0;
		end else begin
			display_valid_out <= 1'b0;
			if (state_reg == ST_DONE) begin
				display_valid_out <= 1'b1;
				if (show_held_reg && (held_active_out || peak_event)) begin
					// A peak found by this sample is shown at once
					display_value_out <= peak_event ? peak_value[13:0] : held_value_reg;
					display_code_out  <= CODE_VALUE;
				end else begin
					display_value_out <= (live_code == CODE_VALUE) ? w_reg[13:0] : 14'sh0000;
					display_code_out  <= live_code;
				end
			end
		end
	end
endmodule : display_value_scaler

// file: display_value_scaler_monitor.sv
// Port checker of the display value scaler
`timescale 1ns/1ps
module display_value_scaler_monitor
	import display_scaler_pkg::*;
(
	input wire logic        mclk_in,
	input wire logic        arst_n_in,
	input wire logic        sample_valid_in,
	input wire logic [6:0]  addr_in,
	input wire logic        rd_strobe_in,
	input wire logic [15:0] rd_data_out,
	input wire logic signed [13:0] display_value_out,
	input wire code_t       display_code_out,
	input wire logic        display_valid_out,
	input wire logic        held_active_out
);
	logic [6:0] since_reg;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);

	// Cycles since the latest offered sample, saturating
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			since_reg <= 7'h7F;
		else if (sample_valid_in)
			since_reg <= 7'h00;
		else if (since_reg != 7'h7F)
			since_reg <= since_reg + 7'h01;
	end

	valid_gap_a: assert property (
		display_valid_out |=> !display_valid_out [*3]) else $error("valid pulses too close");
	valid_cause_a: assert property (
		display_valid_out |-> since_reg >= 7'h03 && since_reg <= 7'h3E) else $error("valid without recent sample");
	result_hold_a: assert property (
		!display_valid_out |-> $stable(display_value_out) && $stable(display_code_out)) else $error("display moved");
	warn_blank_a: assert property (
		display_code_out != CODE_VALUE |-> display_value_out == 14'sh0000) else $error("warning with value");
	shown_floor_a: assert property (
		display_code_out == CODE_VALUE |-> display_value_out >= -14'sh03E7) else $error("value below floor");
	read_idle_a: assert property (
		!$past(rd_strobe_in) |-> rd_data_out == 16'h0000) else $error("read data outside slot");
	read_value_a: assert property (
		$past(rd_strobe_in) && $past(addr_in) == 7'h08 |-> $signed(rd_data_out) == $past(display_value_out))
		else $error("value read mismatch");
	read_status_a: assert property (
		$past(rd_strobe_in) && $past(addr_in) == 7'h09 |->
		rd_data_out == {12'h000, $past(held_active_out), $past(display_code_out)}) else $error("status read mismatch");
endmodule : display_value_scaler_monitor

bind display_value_scaler display_value_scaler_monitor i_display_value_scaler_monitor (
	.mclk_in(mclk_in), .arst_n_in(arst_n_in), .sample_valid_in(sample_valid_in), .addr_in(addr_in),
	.rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out), .display_value_out(display_value_out),
	.display_code_out(display_code_out), .display_valid_out(display_valid_out), .held_active_out(held_active_out));

// file: display_value_scaler_tb.sv
// Self-checking bench of the display value scaler
`timescale 1ns/1ps
module display_value_scaler_tb;
	import display_scaler_pkg::*;
	logic               mclk_in, arst_n_in, req, esc, wr, rd, smp_valid, dvalid, held;
	logic signed [16:0] level, smp;
	logic        [6:0]  addr;
	logic        [15:0] wdata, rdata;
	logic signed [13:0] dval;
	code_t              dcode;
	int                 failures, tests_run, cycles;
	int                 xs[6], ys[6], cur[3];

	current_source_model i_current_source_model (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .req_in(req),
		.level_ua_in(level), .sample_out(smp), .sample_valid_out(smp_valid));
	display_value_scaler #(.HOLD_TICK_CYCLES(10)) i_display_value_scaler (.mclk_in(mclk_in),
		.arst_n_in(arst_n_in), .sample_in(smp), .sample_valid_in(smp_valid), .esc_button_in(esc),
		.addr_in(addr), .wr_data_in(wdata), .wr_strobe_in(wr), .rd_strobe_in(rd), .rd_data_out(rdata),
		.display_value_out(dval), .display_code_out(dcode), .display_valid_out(dvalid), .held_active_out(held));

	initial begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end

	task automatic finish_test;
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("[ERR] %0t run hung", $time);
			finish_test();
		end
	end

	task automatic chk(input logic signed [15:0] seen, input logic signed [15:0] exp, input int tol);
		tests_run++;
		if ((^seen === 1'bx) || (seen !== exp && (seen > exp + tol || seen < exp - tol))) begin
			failures++;
			$display("[ERR] %0t seen %0d expected %0d", $time, seen, exp);
		end
	endtask : chk

	task automatic wreg(input logic [6:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk_in);
		wr <= 1'b0;
		@(posedge mclk_in);
	endtask : wreg

	task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		@(negedge mclk_in);
		chk(rdata, exp, 0);
		@(posedge mclk_in);
	endtask : rchk

	// Offer one sample, check its result, keep samples well apart
	task automatic meas(input int ua, input int exp, input code_t ec, input int eh);
		int n;
		level <= 17'(ua);
		req <= 1'b1;
		@(posedge mclk_in);
		req <= 1'b0;
		n = 0;
		do begin
			@(negedge mclk_in);
			n++;
		end while (dvalid !== 1'b1 && n < 100);
		chk(16'(dvalid), 16'h0001, 0);
		chk(16'(dcode), 16'(ec), 0);
		if (ec == CODE_VALUE)
			chk(dval, 16'(exp), 2);
		if (eh >= 0)
			chk(16'(held), 16'(eh), 0);
		repeat (70) @(posedge mclk_in);
	endtask : meas

	function automatic int expect_v(int ua, int m, int z, int f, int rng);
		real n;
		int i;
		n = rng ? ua / 20000.0 : (ua - 4000) / 16000.0;
		if (m == 3) begin
			i = 0;
			while (i < 4 && n * 1000.0 >= xs[i + 1])
				i++;
			return $rtoi($floor((n - xs[i] / 1000.0) * 1000.0 * (ys[i + 1] - ys[i]) / (xs[i + 1] - xs[i]) + ys[i]));
		end
		if (m == 1)
			n = n * n;
		if (m == 2)
			n = (n < 0.0) ? 0.0 : $sqrt(n);
		return $rtoi($floor(n * (f - z) + z));
	endfunction : expect_v

	task automatic esc_press;
		esc <= 1'b1;
		repeat (4) @(posedge mclk_in);
		esc <= 1'b0;
		repeat (4) @(posedge mclk_in);
	endtask : esc_press

	initial begin
		arst_n_in = 1'b0;
		{req, esc, wr, rd} = 4'h0;
		addr = 7'h00;
		wdata = 16'h0000;
		level = 17'sh00000;
		failures = 0;
		tests_run = 0;
		cycles = 0;
		xs = '{0, 100, 300, 400, 900, 1000};
		ys = '{-50, -30, 30, 80, 900, 820};
		cur = '{10000, 2500, 20500};
		repeat (6) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		@(posedge mclk_in);
		rchk(7'h00, 16'h0000);
		rchk(7'h02, 16'h03E8);
		rchk(7'h10, 16'h0000);
		wreg(7'h03, 16'h0190);
		wreg(7'h04, 16'h001E);
		wreg(7'h01, 16'hFED4);
		wreg(7'h02, 16'h04B0);
		for (int m = 0; m < 3; m++) begin
			wreg(7'h00, 16'(m));
			foreach (cur[k])
				meas(cur[k], expect_v(cur[k], m, -300, 1200, 0), CODE_VALUE, -1);
		end
		wreg(7'h00, 16'h0004);
		wreg(7'h01, 16'h03E8);
		wreg(7'h02, 16'h0000);
		meas(5000, 750, CODE_VALUE, -1);
		meas(-1, 0, CODE_BELOW, -1);
		rchk(7'h09, 16'h0002);
		wreg(7'h00, 16'h0000);
		wreg(7'h03, 16'h0000);
		wreg(7'h04, 16'h0000);
		meas(3999, 0, CODE_BELOW, -1);
		meas(20001, 0, CODE_ABOVE, -1);
		wreg(7'h03, 16'h0190);
		wreg(7'h04, 16'h00C7);
		wreg(7'h01, 16'hE0C0);
		wreg(7'h02, 16'h1F40);
		meas(23200, 0, CODE_OVERFLOW, -1);
		meas(3000, 0, CODE_OVERFLOW, -1);
		wreg(7'h00, 16'h0003);
		wreg(7'h07, 16'h0001);
		meas(10000, 0, CODE_TOO_FEW, -1);
		wreg(7'h07, 16'h0019);
		rchk(7'h07, 16'h0014);
		for (int i = 0; i < 6; i++) begin
			wreg(7'h20 + 7'(i), 16'(xs[i]));
			wreg(7'h40 + 7'(i), 16'(ys[i]));
		end
		wreg(7'h07, 16'h0006);
		foreach (cur[k])
			meas(cur[k], expect_v(cur[k], 3, 0, 0, 0), CODE_VALUE, -1);
		// Second reset gives a clean detector
		arst_n_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		@(posedge mclk_in);
		wreg(7'h00, 16'h0010);
		wreg(7'h05, 16'h0064);
		meas(4000, 0, CODE_VALUE, 0);
		meas(12000, 500, CODE_VALUE, 0);
		meas(11000, 437, CODE_VALUE, 0);
		meas(9000, 500, CODE_VALUE, 1);
		meas(4000, 500, CODE_VALUE, 1);
		esc_press();
		chk(16'(held), 16'h0000, 0);
		meas(4000, 0, CODE_VALUE, 0);
		wreg(7'h06, 16'h0002);
		meas(12000, 500, CODE_VALUE, -1);
		meas(6000, 500, CODE_VALUE, 1);
		chk(16'(held), 16'h0000, 0);
		meas(6000, 125, CODE_VALUE, 0);
		wreg(7'h06, 16'h0000);
		wreg(7'h00, 16'h0018);
		meas(12000, 500, CODE_VALUE, -1);
		meas(4000, 0, CODE_VALUE, -1);
		meas(8000, 0, CODE_VALUE, 1);
		finish_test();
	end
endmodule : display_value_scaler_tb

// file: seg_divider.sv
// Sequential restoring unsigned divider
`timescale 1ns/1ps
module seg_divider #(
	parameter int W = 32
) (
	input  wire logic         mclk_in,
	input  wire logic         arst_n_in,
	input  wire logic         start_in,
	input  wire logic [W-1:0] dividend_in,
	input  wire logic [W-1:0] divisor_in,
	output logic      [W-1:0] quotient_out,
	output logic              done_out
);
	localparam int CW = $clog2(W + 1);
	logic [W:0]    rem_reg;
	logic [W-1:0]  dvs_reg;
	logic [CW-1:0] cnt_reg;
	logic          busy_reg;
	logic [W:0]    trial;

	assign trial = {rem_reg[W-1:0], quotient_out[W-1]};

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rem_reg      <= '0;
			dvs_reg      <= '0;
			cnt_reg      <= '0;
			busy_reg     <= 1'b0;
			quotient_out <= '0;
			done_out     <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in) begin
				rem_reg      <= '0;
				dvs_reg      <= divisor_in;
				quotient_out <= dividend_in;
				cnt_reg      <= CW'(W);
				busy_reg     <= 1'b1;
			end else if (busy_reg) begin
				// Zero divisor gives all ones
				if (trial >= {1'b0, dvs_reg}) begin
					rem_reg      <= trial - {1'b0, dvs_reg};
					quotient_out <= {quotient_out[W-2:0], 1'b1};
				end else begin
					rem_reg      <= trial;
					quotient_out <= {quotient_out[W-2:0], 1'b0};
				end
				cnt_reg <= cnt_reg - CW'(1);
				if (cnt_reg == CW'(1)) begin
					busy_reg <= 1'b0;
					done_out <= 1'b1;
				end
			end
		end
	end
endmodule : seg_divider
